// ==== aps_pkg.sv ====
// Constants and state type of the actuator and power supervisor
package aps_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS_CYC = CLK_HZ / MS_PER_S;
  localparam int SYNC_W = 76;
  localparam int ACT_I_STEP = 40;
  localparam int ACT_TMO_STEP_MS = 10;
  localparam int SLEEP_STEP_MS = 60_000;
  localparam int SVC_STEP_H = 10;
  localparam int SVC_WIN_MS = 20_000;
  localparam int SVC_ON_MS = 900;
  localparam int SVC_OFF_MS = 100;
  localparam int FLASH_PER_MS = SVC_ON_MS + SVC_OFF_MS;
  localparam int LOWB_ON_MS = 500;
  localparam int LVC_BASE_MV = 16_000;
  localparam int LVC_STEP_MV = 500;
  localparam int LV_STEP_MS = 1000;
  localparam int GAUGE_EMPTY_MV = 21_000;
  localparam int GAUGE_STEP_MV = 400;
  localparam int BARS_MAX = 10;
  localparam int VOL_MAX = 10;
  localparam int JS_DEAD = 8;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [2:0] btn_prev;
    logic [1:0] lr_prev;
    logic [17:0] tick_cnt;
    logic sel;
    logic [1:0][8:0] act_ms;
    logic [1:0] act_stall;
    logic [1:0] act_up;
    logic [1:0] act_dn;
    logic es_bleep;
    logic [20:0] sleep_ms;
    logic off;
    logic [17:0] lv_ms;
    logic cut;
    logic [14:0] up_ms;
    logic [9:0] flash_ms;
    logic svc_act;
    logic svc_due;
    logic gauge_blank;
    logic [3:0] bars;
    logic [16:0] gauge_mv;
    logic alarm;
    logic btn_bleep;
    logic [3:0] bleep_vol;
    logic spd_up;
    logic spd_dn;
    logic signed [8:0] drive;
    logic signed [9:0] steer;
  } aps_st_s;
endpackage : aps_pkg

// ==== aps_supervisor.sv ====
// Actuator end-stop, joystick mapping, sleep, gauge and low-voltage supervisor
//
// Behaviour
// - Each actuator channel holds end force 1..5
// - Stall current held for timeout, then drive removed
// - Joystick left/right selects channel when enabled
// - Joystick selection only with more than one actuator
// - Detection off never stops an actuator
// - Bleep on end-stop stall when enabled
// - Power off after sleep minutes undriven
// - Sleep time zero never powers off
// - Inversion swaps forward and reverse drive
// - Inversion leaves steering axis alone
// - Signed steer trim, reversed by motor swap
// - Button bleep at volume, zero is silent
// - Speed buttons gated while driving unless enabled
// - Service due after interval x 10 hours, zero off
// - Service flash 900/100 ms for 20 s
// - Diagnostic indication overrides service flash
// - Gauge flashes slowly at low bar level
// - Cable resistance compensates gauge under load
// - Low battery alarm at flash level when enabled
// - Cut-out level 16 V to 23.5 V
// - Cease after voltage low for set seconds
`timescale 1ns/100ps
module aps_supervisor #(
  parameter int TICK_MS_CYC = aps_pkg::TICK_MS_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [7:0] js_x,
  input wire logic signed [7:0] js_y,
  input wire logic btn_spd_up,
  input wire logic btn_spd_dn,
  input wire logic btn_act,
  input wire logic act_up_req,
  input wire logic act_dn_req,
  input wire logic chair_moving,
  input wire logic [7:0] act_cur0,
  input wire logic [7:0] act_cur1,
  input wire logic [15:0] vbat_mv,
  input wire logic [7:0] ibat_a,
  input wire logic [13:0] run_hours,
  input wire logic [1:0] num_act,
  input wire logic [2:0] end_force0,
  input wire logic [2:0] end_force1,
  input wire logic [5:0] act_tmo0,
  input wire logic [5:0] act_tmo1,
  input wire logic js_act_sel,
  input wire logic es_detect,
  input wire logic es_bleep_en,
  input wire logic [4:0] sleep_min,
  input wire logic js_invert,
  input wire logic signed [4:0] steer_trim,
  input wire logic swap_motors,
  input wire logic [3:0] bleep_vol_set,
  input wire logic spd_adj_drive,
  input wire logic [9:0] svc_interval,
  input wire logic diag_active,
  input wire logic [3:0] lowb_level,
  input wire logic [7:0] cable_mohm,
  input wire logic lowb_alarm_en,
  input wire logic [3:0] lvc_code,
  input wire logic [7:0] lv_time_s,
  output logic [1:0] act_up_drv,
  output logic [1:0] act_dn_drv,
  output logic act_chan,
  output logic endstop_bleep,
  output logic btn_bleep,
  output logic [3:0] bleep_vol,
  output logic spd_up_ok,
  output logic spd_dn_ok,
  output logic signed [8:0] drive_dem,
  output logic signed [9:0] steer_dem,
  output logic power_off,
  output logic lv_cutout,
  output logic service_due,
  output logic [3:0] gauge_bars,
  output logic gauge_blank,
  output logic [16:0] gauge_mv,
  output logic low_batt_alarm
);

  localparam logic signed [7:0] DEAD = 8'(aps_pkg::JS_DEAD);

  function automatic logic outside_dead(input logic signed [7:0] v);
    outside_dead = (v > DEAD) || (v < -DEAD);
  endfunction : outside_dead

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_r;
  logic rst_q;
  aps_pkg::aps_st_s q;
  aps_pkg::aps_st_s n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  logic signed [7:0] sx;
  logic signed [7:0] sy;
  logic s_up, s_dn, s_abtn, s_aup, s_adn, s_mov;
  logic [7:0] s_cur1, s_cur0;
  logic [15:0] s_vbat;
  logic [7:0] s_ibat;
  logic [13:0] s_hours;
  assign {sx, sy, s_up, s_dn, s_abtn, s_aup, s_adn, s_mov, s_cur1, s_cur0, s_vbat, s_ibat,
          s_hours} = q.s2;

  logic [2:0] btn_rise;
  logic js_l, js_r, deflect, tick, halt, joy_sel_en, spd_ok, below, svc_act, lowb;
  logic [1:0] act_cmd, act_hit;
  logic [1:0][8:0] act_tmo_ms;
  logic [16:0] vcomp;
  localparam int BARS_W = aps_pkg::BARS_MAX;
  logic [BARS_W-1:0] bar_hit;
  logic [3:0] bars;
  logic signed [9:0] trim_eff;
  logic signed [8:0] sy9;

  assign btn_rise = {s_up, s_dn, s_abtn} & ~q.btn_prev;
  assign js_l = sx < -DEAD;
  assign js_r = sx > DEAD;
  assign deflect = outside_dead(sx) || outside_dead(sy);
  assign tick = q.tick_cnt == 18'(TICK_MS_CYC - 1);
  assign halt = q.off || q.cut;
  assign joy_sel_en = js_act_sel && (num_act > 2'h1);
  assign spd_ok = spd_adj_drive || (!deflect && !s_mov);
  assign below = s_vbat < 16'(aps_pkg::LVC_BASE_MV + lvc_code * aps_pkg::LVC_STEP_MV);
  // Load current times cable resistance gives the drop to add back (A x mOhm = mV)
  assign vcomp = {1'b0, s_vbat} + {9'h000, s_ibat} * {9'h000, cable_mohm};
  assign bars = 4'($countones(bar_hit));
  assign lowb = bars <= lowb_level;
  assign svc_act = q.svc_due && (q.up_ms < 15'(aps_pkg::SVC_WIN_MS)) && !diag_active;
  assign trim_eff = swap_motors ? -10'(steer_trim) : 10'(steer_trim);
  assign sy9 = 9'(sy);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_act
      logic [7:0] cur;
      logic [2:0] force_lvl;
      logic [5:0] tmo;
      assign cur = (gi == 0) ? s_cur0 : s_cur1;
      assign force_lvl = (gi == 0) ? end_force0 : end_force1;
      assign tmo = (gi == 0) ? act_tmo0 : act_tmo1;
      assign act_cmd[gi] = (q.sel == 1'(gi)) && (s_aup ^ s_adn) && !halt;
      assign act_hit[gi] = {1'b0, cur} >= 9'(force_lvl * aps_pkg::ACT_I_STEP);
      assign act_tmo_ms[gi] = 9'(tmo * aps_pkg::ACT_TMO_STEP_MS);
    end
    for (gi = 0; gi < BARS_W; gi++) begin : g_bar
      assign bar_hit[gi] = vcomp >=
        17'(aps_pkg::GAUGE_EMPTY_MV + (gi + 1) * aps_pkg::GAUGE_STEP_MV);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.s1 = {js_x, js_y, btn_spd_up, btn_spd_dn, btn_act, act_up_req, act_dn_req,
            chair_moving, act_cur1, act_cur0, vbat_mv, ibat_a, run_hours};
    n.s2 = q.s1;
    n.btn_prev = {s_up, s_dn, s_abtn};
    n.lr_prev = {js_l, js_r};
    n.tick_cnt = tick ? 18'h00000 : q.tick_cnt + 18'h00001;
    // Actuator button always toggles; joystick edges only when enabled
    if (btn_rise[0]) begin
      n.sel = ~q.sel;
    end else if (joy_sel_en && js_l && !q.lr_prev[1]) begin
      n.sel = 1'b0;
    end else if (joy_sel_en && js_r && !q.lr_prev[0]) begin
      n.sel = 1'b1;
    end
    n.es_bleep = 1'b0;
    for (int c = 0; c < 2; c++) begin
      // Stall holds until the command is released, since the dead motor draws no current
      if (!act_cmd[c] || !es_detect) begin
        n.act_ms[c] = 9'h000;
        n.act_stall[c] = 1'b0;
      end else if (q.act_stall[c]) begin
        n.act_ms[c] = q.act_ms[c];
      end else if (!act_hit[c]) begin
        n.act_ms[c] = 9'h000;
      end else if (tick) begin
        n.act_ms[c] = q.act_ms[c] + 9'h001;
        if (q.act_ms[c] + 9'h001 >= act_tmo_ms[c]) begin
          n.act_stall[c] = 1'b1;
          n.es_bleep = es_bleep_en;
        end
      end
      n.act_up[c] = act_cmd[c] && !n.act_stall[c] && s_aup;
      n.act_dn[c] = act_cmd[c] && !n.act_stall[c] && s_adn;
    end
    if (deflect || s_mov) begin
      n.sleep_ms = 21'h000000;
    end else if (tick && !q.off && sleep_min != 5'h00) begin
      n.sleep_ms = q.sleep_ms + 21'h000001;
      if (q.sleep_ms + 21'h000001 >= 21'(sleep_min * aps_pkg::SLEEP_STEP_MS)) begin
        n.off = 1'b1;
      end
    end
    if (!below) begin
      n.lv_ms = 18'h00000;
    end else if (tick && !q.cut) begin
      n.lv_ms = q.lv_ms + 18'h00001;
      if (q.lv_ms + 18'h00001 >= 18'(lv_time_s * aps_pkg::LV_STEP_MS)) begin
        n.cut = 1'b1;
      end
    end
    if (tick && q.up_ms < 15'(aps_pkg::SVC_WIN_MS)) begin
      n.up_ms = q.up_ms + 15'h0001;
    end
    if (tick) begin
      n.flash_ms = (q.flash_ms == 10'(aps_pkg::FLASH_PER_MS - 1)) ? 10'h000
                   : q.flash_ms + 10'h001;
    end
    n.svc_due = (svc_interval != 10'h000) &&
                (s_hours >= 14'(svc_interval * aps_pkg::SVC_STEP_H));
    n.svc_act = svc_act;
    if (svc_act) begin
      n.gauge_blank = q.flash_ms >= 10'(aps_pkg::SVC_ON_MS);
    end else begin
      n.gauge_blank = lowb && (q.flash_ms >= 10'(aps_pkg::LOWB_ON_MS));
    end
    n.bars = bars;
    n.gauge_mv = vcomp;
    n.alarm = lowb_alarm_en && lowb;
    n.btn_bleep = (|btn_rise) && (bleep_vol_set != 4'h0);
    n.bleep_vol = (bleep_vol_set > 4'(aps_pkg::VOL_MAX)) ? 4'(aps_pkg::VOL_MAX) : bleep_vol_set;
    n.spd_up = btn_rise[2] && spd_ok;
    n.spd_dn = btn_rise[1] && spd_ok;
    n.drive = halt ? 9'sh000 : (js_invert ? -sy9 : sy9);
    n.steer = halt ? 10'sh000 : 10'(sx) + trim_eff;
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign act_up_drv = q.act_up;
  assign act_dn_drv = q.act_dn;
  assign act_chan = q.sel;
  assign endstop_bleep = q.es_bleep;
  assign btn_bleep = q.btn_bleep;
  assign bleep_vol = q.bleep_vol;
  assign spd_up_ok = q.spd_up;
  assign spd_dn_ok = q.spd_dn;
  assign drive_dem = q.drive;
  assign steer_dem = q.steer;
  assign power_off = q.off;
  assign lv_cutout = q.cut;
  assign service_due = q.svc_due;
  assign gauge_bars = q.bars;
  assign gauge_blank = q.gauge_blank;
  assign gauge_mv = q.gauge_mv;
  assign low_batt_alarm = q.alarm;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q);

  stall_cut_a: assert property (q.act_stall[0] |-> !q.act_up[0] && !q.act_dn[0])
    else $error("stalled channel still driven");
  no_detect_a: assert property (!es_detect |=> q.act_stall == 2'h0)
    else $error("stall flagged with detection off");
  es_bleep_a: assert property ($rose(q.act_stall[0]) |-> q.es_bleep == $past(es_bleep_en))
    else $error("end-stop bleep mismatch");
  joy_sel_a: assert property (!joy_sel_en && !btn_rise[0] |=> $stable(q.sel))
    else $error("channel changed without a permitted source");
  sleep_zero_a: assert property (sleep_min == 5'h00 && !q.off |=> !q.off)
    else $error("powered off with sleep disabled");
  sleep_rst_a: assert property (deflect || s_mov |=> q.sleep_ms == 21'h000000)
    else $error("sleep timer not restarted");
  lv_rst_a: assert property (!below |=> q.lv_ms == 18'h00000)
    else $error("low-voltage timer not restarted");
  invert_a: assert property (!halt && js_invert |=> q.drive == -$past(sy9))
    else $error("inverted drive wrong");
  vol_zero_a: assert property (bleep_vol_set == 4'h0 |=> !q.btn_bleep)
    else $error("bleep with zero volume");
  spd_gate_a: assert property (!spd_adj_drive && s_mov |=> !q.spd_up && !q.spd_dn)
    else $error("speed button accepted while moving");
  diag_over_a: assert property (diag_active |=> !q.svc_act)
    else $error("service flash over diagnostic");
  alarm_off_a: assert property (!lowb_alarm_en |=> !q.alarm)
    else $error("alarm sounded while disabled");

  stall_c: cover property ($rose(q.act_stall[1]));
  sleep_c: cover property ($rose(q.off));
  cut_c: cover property ($rose(q.cut));
  spd_c: cover property (q.spd_up && s_mov);

endmodule : aps_supervisor

// ==== aps_act_model.sv ====
// Behavioural actuator motor that stalls at the end of its travel
`timescale 1ns/100ps
module aps_act_model #(
  parameter int TRAVEL = 100
) (
  input wire logic clk,
  input wire logic drv,
  output logic [7:0] cur
);
  int pos = 0;
  // Travel is never undone, so a later drive finds the motor already stalled
  always_ff @(posedge clk) begin
    if (drv && pos < TRAVEL) begin
      pos <= pos + 1;
    end
  end
  // Stall current sits at the top force level, running current below the lowest
  assign cur = !drv ? 8'H00 : (pos >= TRAVEL ? 8'HC8 : 8'H1E);
endmodule : aps_act_model

// ==== aps_supervisor_bench.sv ====
// Self-checking bench for the actuator and power supervisor
`timescale 1ns/100ps
module aps_supervisor_bench;
  logic clk = 0, rst_n = 0;
  logic signed [7:0] js_x = 0, js_y = 0;
  logic btn_spd_up = 0, btn_spd_dn = 0, btn_act = 0, act_up_req = 0, act_dn_req = 0;
  logic chair_moving = 0, js_act_sel = 0, es_detect = 1, es_bleep_en = 1, js_invert = 0;
  logic swap_motors = 0, spd_adj_drive = 0, diag_active = 0, lowb_alarm_en = 1;
  logic [7:0] act_cur0, act_cur1, ibat_a = 8'H0A, cable_mohm = 8'H64, lv_time_s = 8'H01;
  logic [15:0] vbat_mv = 16'H55F0;
  logic [13:0] run_hours = 14'H0000;
  logic [1:0] num_act = 2'H2;
  logic [2:0] end_force0 = 3'H2, end_force1 = 3'H5;
  logic [5:0] act_tmo0 = 6'H05, act_tmo1 = 6'H32;
  logic [4:0] sleep_min = 5'H00;
  logic signed [4:0] steer_trim = 5'sH03;
  logic [3:0] bleep_vol_set = 4'H3, lowb_level = 4'H5, lvc_code = 4'H4;
  logic [9:0] svc_interval = 10'H000;
  logic [1:0] act_up_drv, act_dn_drv;
  logic act_chan, endstop_bleep, btn_bleep, spd_up_ok, spd_dn_ok, power_off, lv_cutout;
  logic service_due, gauge_blank, low_batt_alarm;
  logic [3:0] bleep_vol, gauge_bars;
  logic signed [8:0] drive_dem;
  logic signed [9:0] steer_dem;
  logic [16:0] gauge_mv;
  int n_mismatch = 0, samples_checked = 0;

  // Millisecond tick shortened to 10 cycles so timeouts fit the run
  aps_supervisor #(.TICK_MS_CYC(10)) u_aps_supervisor (
    .clk(clk), .rst_n(rst_n), .js_x(js_x), .js_y(js_y), .btn_spd_up(btn_spd_up),
    .btn_spd_dn(btn_spd_dn), .btn_act(btn_act), .act_up_req(act_up_req),
    .act_dn_req(act_dn_req), .chair_moving(chair_moving), .act_cur0(act_cur0),
    .act_cur1(act_cur1), .vbat_mv(vbat_mv), .ibat_a(ibat_a), .run_hours(run_hours),
    .num_act(num_act), .end_force0(end_force0), .end_force1(end_force1),
    .act_tmo0(act_tmo0), .act_tmo1(act_tmo1), .js_act_sel(js_act_sel),
    .es_detect(es_detect), .es_bleep_en(es_bleep_en), .sleep_min(sleep_min),
    .js_invert(js_invert), .steer_trim(steer_trim), .swap_motors(swap_motors),
    .bleep_vol_set(bleep_vol_set), .spd_adj_drive(spd_adj_drive),
    .svc_interval(svc_interval), .diag_active(diag_active), .lowb_level(lowb_level),
    .cable_mohm(cable_mohm), .lowb_alarm_en(lowb_alarm_en), .lvc_code(lvc_code),
    .lv_time_s(lv_time_s), .act_up_drv(act_up_drv), .act_dn_drv(act_dn_drv),
    .act_chan(act_chan), .endstop_bleep(endstop_bleep), .btn_bleep(btn_bleep),
    .bleep_vol(bleep_vol), .spd_up_ok(spd_up_ok), .spd_dn_ok(spd_dn_ok),
    .drive_dem(drive_dem), .steer_dem(steer_dem), .power_off(power_off),
    .lv_cutout(lv_cutout), .service_due(service_due), .gauge_bars(gauge_bars),
    .gauge_blank(gauge_blank), .gauge_mv(gauge_mv), .low_batt_alarm(low_batt_alarm)
  );
  aps_act_model u_act0 (.clk(clk), .drv(act_up_drv[0] | act_dn_drv[0]), .cur(act_cur0));
  aps_act_model u_act1 (.clk(clk), .drv(act_up_drv[1] | act_dn_drv[1]), .cur(act_cur1));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task final_report;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task check(input string what, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // One full flash period of the gauge is 10000 cycles at the shortened tick
  task count_blank(output int nbl);
    nbl = 0;
    repeat (10000) begin
      step(1);
      nbl += (gauge_blank === 1'b1);
    end
  endtask : count_blank

  ////////////////////////////////////////////////////////////////////////////
  task press(input bit dn, output int nb, output int nok);
    nb = 0;
    nok = 0;
    @(posedge clk) btn_spd_up <= !dn;
    btn_spd_dn <= dn;
    repeat (10) begin
      step(1);
      nb += (btn_bleep === 1'b1);
      nok += ((dn ? spd_dn_ok : spd_up_ok) === 1'b1);
    end
    @(posedge clk) btn_spd_up <= 0;
    btn_spd_dn <= 0;
    step(6);
  endtask : press

  task t_map;
    @(posedge clk) js_y <= 8'sH28;
    js_x <= 8'sH14;
    step(6);
    check("drive", 17'sH28, 17'(drive_dem));
    check("steer", 17'sH17, 17'(steer_dem));
    @(posedge clk) js_invert <= 1;
    swap_motors <= 1;
    step(6);
    check("drive_inv", -17'sH28, 17'(drive_dem));
    check("steer_inv", 17'sH11, 17'(steer_dem));
    @(posedge clk) js_x <= 0;
    js_y <= 0;
    step(6);
  endtask : t_map

  task t_btn;
    int nb, nok;
    @(posedge clk) chair_moving <= 1;
    press(0, nb, nok);
    check("bleep", 17'H1, 17'(nb));
    check("spd_refused", 17'H0, 17'(nok));
    check("vol", 17'H3, 17'(bleep_vol));
    @(posedge clk) spd_adj_drive <= 1;
    press(1, nb, nok);
    check("spd_moving", 17'H1, 17'(nok));
    @(posedge clk) bleep_vol_set <= 0;
    chair_moving <= 0;
    press(0, nb, nok);
    check("bleep_off", 17'H0, 17'(nb));
  endtask : t_btn

  task t_chan;
    @(posedge clk) btn_act <= 1;
    step(6);
    check("chan_btn", 17'H1, 17'(act_chan));
    @(posedge clk) btn_act <= 0;
    num_act <= 2'H1;
    js_act_sel <= 1;
    js_x <= -8'sH3C;
    step(8);
    check("chan_single", 17'H1, 17'(act_chan));
    @(posedge clk) num_act <= 2'H2;
    js_x <= 0;
    step(6);
    @(posedge clk) js_x <= -8'sH3C;
    step(6);
    check("chan_js", 17'H0, 17'(act_chan));
    @(posedge clk) js_x <= 0;
    js_act_sel <= 0;
    step(6);
  endtask : t_chan

  task t_stall;
    int n;
    n = 0;
    @(posedge clk) act_up_req <= 1;
    while (act_cur0 < 8'H50 && n < 400) begin
      step(1);
      n++;
    end
    check("chan1_idle", 17'H0, 17'(act_up_drv[1]));
    n = 0;
    while (act_up_drv[0] === 1'b1 && n < 900) begin
      step(1);
      n++;
    end
    check("stall_early", 17'H1, 17'(n > 470));
    check("stall_late", 17'H1, 17'(n < 540));
    check("es_bleep", 17'H1, 17'(endstop_bleep));
    @(posedge clk) act_up_req <= 0;
    es_detect <= 0;
    step(6);
    @(posedge clk) act_dn_req <= 1;
    step(700);
    check("no_detect", 17'H1, 17'(act_dn_drv[0]));
    @(posedge clk) act_dn_req <= 0;
    es_detect <= 1;
    step(6);
  endtask : t_stall

  task t_gauge;
    int nbl;
    check("gauge_mv", 17'H59D8, gauge_mv);
    check("bars", 17'H5, 17'(gauge_bars));
    check("alarm", 17'H1, 17'(low_batt_alarm));
    count_blank(nbl);
    check("slow_flash", 17'H1, 17'(nbl > 4900 && nbl < 5100));
    @(posedge clk) lowb_alarm_en <= 0;
    step(4);
    check("alarm_off", 17'H0, 17'(low_batt_alarm));
  endtask : t_gauge

  // The whole run sits inside the 20 s window after reset
  task t_svc;
    int nbl;
    @(posedge clk) svc_interval <= 10'H001;
    run_hours <= 14'H000A;
    step(6);
    check("svc_due", 17'H1, 17'(service_due));
    count_blank(nbl);
    check("svc_flash", 17'H1, 17'(nbl > 950 && nbl < 1050));
    @(posedge clk) diag_active <= 1;
    step(4);
    count_blank(nbl);
    check("svc_diag", 17'H1, 17'(nbl > 4900 && nbl < 5100));
    @(posedge clk) diag_active <= 0;
    svc_interval <= 10'H000;
    step(4);
    check("svc_off", 17'H0, 17'(service_due));
  endtask : t_svc

  // Cut-out is sticky, so this runs last
  task t_lv;
    @(posedge clk) vbat_mv <= 16'H4268;
    step(5000);
    @(posedge clk) vbat_mv <= 16'H4E20;
    step(20);
    @(posedge clk) vbat_mv <= 16'H4268;
    step(9000);
    check("lv_restart", 17'H0, 17'(lv_cutout));
    step(2000);
    check("lv_cut", 17'H1, 17'(lv_cutout));
    check("no_sleep", 17'H0, 17'(power_off));
  endtask : t_lv

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(4);
    check("reset_out", 17'H0, 17'({act_up_drv, power_off, lv_cutout, btn_bleep}));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    step(6);
    t_map;
    t_btn;
    t_chan;
    t_stall;
    t_gauge;
    t_svc;
    t_lv;
    final_report;
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule : aps_supervisor_bench
